// File: src/pbg_consts.vh
`ifndef PBG_CONSTS_VH
`define PBG_CONSTS_VH

// ----------------------------------------------------------------------
// bus geometry and answers
// ----------------------------------------------------------------------
`define PBG_ADDR_W          8
`define PBG_RESP_OKAY       2'h0
`define PBG_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PBG_OFS_PIN_STATE   8'h00
`define PBG_OFS_DIRECTION   8'h04
`define PBG_OFS_ANALOG_SEL  8'h08
`define PBG_OFS_PULLUP_EN   8'h0C
`define PBG_OFS_CHANGE_EN   8'h10
`define PBG_OFS_OPTION      8'h14
`define PBG_OFS_INT_CTRL    8'h18

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PBG_RST_LATCH       8'h00
`define PBG_RST_DIRECTION   8'hFF
`define PBG_RST_ANALOG_SEL  8'h3F
`define PBG_RST_PULLUP_EN   8'hFF
`define PBG_RST_CHANGE_EN   8'h00
`define PBG_RST_LAST_READ   8'h00
`define PBG_RST_GPU_DIS     1'h1

// ----------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------
`define PBG_ANALOG_MASK     8'h3F
`define PBG_BIT_GPU_DIS     0
`define PBG_BIT_CHG_FLAG    0
`define PBG_BIT_CHG_IE      1

`endif

// File: src/pbg_sync2.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// two-flop synchroniser for the eight pad inputs
// ----------------------------------------------------------------------
module pbg_sync2 (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] d,
    output wire [7:0] q
);
    reg [7:0] stage1_q;
    reg [7:0] stage2_q;

    // first stage feeds only the second one
    always @(posedge clk) begin
        if (!rst_n) begin
            stage1_q <= 8'h00;
            stage2_q <= 8'h00;
        end else begin
            stage1_q <= d;
            stage2_q <= stage1_q;
        end
    end

    assign q = stage2_q;
endmodule // pbg_sync2

// File: src/pbg_axil_slave.v
`timescale 1ns/1ps
`include "pbg_consts.vh"

// ----------------------------------------------------------------------
// axi4-lite slave front end: one write and one read in flight
// ----------------------------------------------------------------------
module pbg_axil_slave (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        wr_en,
    output wire [7:0]  wr_addr,
    output wire [31:0] wr_data,
    output wire [3:0]  wr_strb,
    input  wire        wr_err,
    output wire        rd_en,
    output wire [7:0]  rd_addr,
    input  wire [31:0] rd_data,
    input  wire        rd_err
);
    reg        aw_full_q;
    reg [7:0]  aw_addr_q;
    reg        w_full_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;

    // address and data may arrive in either order; hold each until both
    assign s_axi_awready = ~aw_full_q & ~bvalid_q;
    assign s_axi_wready  = ~w_full_q & ~bvalid_q;
    assign wr_en   = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_addr = aw_addr_q;
    assign wr_data = w_data_q;
    assign wr_strb = w_strb_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // write channel capture and response
    always @(posedge clk) begin
        if (!rst_n) begin
            aw_full_q <= 1'h0;
            aw_addr_q <= 8'h00;
            w_full_q  <= 1'h0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'h0;
            bresp_q   <= `PBG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'h1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'h1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_full_q <= 1'h0;
                w_full_q  <= 1'h0;
                bvalid_q  <= 1'h1;
                bresp_q   <= wr_err ? `PBG_RESP_SLVERR : `PBG_RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'h0;
            end
        end
    end

    // read: data sampled at the address handshake edge
    assign s_axi_arready = ~rvalid_q;
    assign rd_en   = s_axi_arvalid & ~rvalid_q;
    assign rd_addr = s_axi_araddr;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'h0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `PBG_RESP_OKAY;
        end else if (rd_en) begin
            rvalid_q <= 1'h1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_err ? `PBG_RESP_SLVERR : `PBG_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'h0;
        end
    end
endmodule // pbg_axil_slave

// File: src/pbg_port_b_top.v
// Overview of operation
// - direction bit one: pin input, driver off
// - direction bit zero: drive output latch value
// - port read gives pins, write sets latch
// - port writes without lane 0 are read-modify-write
// - direction still gates drivers on analog pins
// - analog-select pin reads digital zero
// - analog-select changes digital output only through read-modify-write
// - eight per-pin weak pull-up enables
// - pull-up off whenever pin is output
// - power-on sets global pull-up disable
// - eight per-pin change-enable bits
// - change detection disabled after power-on
// - compare pins to last-access latch per pin
// - or mismatches into change flag
// - set change flag can wake from sleep
// - persistent mismatch keeps setting change flag
// - last-read latch survives clear and brown-out
// - change during port read still sets flag
// - pull-ups need global disable clear, one enables
`timescale 1ns/1ps
`include "pbg_consts.vh"

module pbg_port_b_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        por_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  port_b_pins_i,
    output wire [7:0]  port_b_pins_o,
    output wire [7:0]  port_b_pins_oe_n,
    output wire [7:0]  port_b_pullup_on,
    output wire [7:0]  port_b_analog_on,
    output wire        port_b_change_flag,
    output wire        port_b_wake
);

    // ------------------------------------------------------------------
    // register selection codes
    // ------------------------------------------------------------------
    localparam [2:0] SEL_PIN    = 3'h0;
    localparam [2:0] SEL_DIR    = 3'h1;
    localparam [2:0] SEL_ANALOG = 3'h2;
    localparam [2:0] SEL_PULLUP = 3'h3;
    localparam [2:0] SEL_CHANGE = 3'h4;
    localparam [2:0] SEL_OPTION = 3'h5;
    localparam [2:0] SEL_INTCTL = 3'h6;
    localparam [2:0] SEL_NONE   = 3'h7;

    // decode shared by the read and the write path
    function [2:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `PBG_OFS_PIN_STATE:  reg_sel = SEL_PIN;
                `PBG_OFS_DIRECTION:  reg_sel = SEL_DIR;
                `PBG_OFS_ANALOG_SEL: reg_sel = SEL_ANALOG;
                `PBG_OFS_PULLUP_EN:  reg_sel = SEL_PULLUP;
                `PBG_OFS_CHANGE_EN:  reg_sel = SEL_CHANGE;
                `PBG_OFS_OPTION:     reg_sel = SEL_OPTION;
                `PBG_OFS_INT_CTRL:   reg_sel = SEL_INTCTL;
                default:             reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wire        wr_en;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        rd_en;
    wire [7:0]  rd_addr;
    reg  [31:0] rd_data;
    wire [2:0]  wr_sel;
    wire [2:0]  rd_sel;
    wire        wr_lane0;
    wire        rst_any_n;
    wire [7:0]  pins_sync;
    wire [7:0]  pins_digital;
    wire [7:0]  mismatch;
    wire [7:0]  pullup_d;
    wire        change_any;
    wire        port_access;
    wire        wr_intctl;

    reg  [7:0]  latch_q;
    reg  [7:0]  latch_d;
    reg  [7:0]  direction_q;
    reg  [7:0]  analog_q;
    reg  [7:0]  pullup_en_q;
    reg  [7:0]  change_en_q;
    reg         gpu_dis_q;
    reg         change_ie_q;
    reg         flag_q;
    reg         flag_d;
    reg  [7:0]  last_read_q;
    reg  [7:0]  pullup_q;
    reg         wake_q;

    // master-clear and brown-out come on rst_n, power-on on por_n
    assign rst_any_n = rst_n & por_n;

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    pbg_axil_slave u_bus (
        .clk           (clk),
        .rst_n         (rst_any_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_sel == SEL_NONE),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_sel == SEL_NONE)
    );

    assign wr_sel   = reg_sel(wr_addr);
    assign rd_sel   = reg_sel(rd_addr);
    assign wr_lane0 = wr_en & wr_strb[0];

    // ------------------------------------------------------------------
    // pin input path
    // ------------------------------------------------------------------
    pbg_sync2 u_sync (
        .clk   (clk),
        .rst_n (rst_any_n),
        .d     (port_b_pins_i),
        .q     (pins_sync)
    );

    // analog pins have their digital buffer off and read as zero
    assign pins_digital = pins_sync & ~analog_q;

    // ------------------------------------------------------------------
    // per-pin pull-up and change detection
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            // pull-up only on an input pin with the global disable clear
            assign pullup_d[gi] = ~gpu_dis_q
                                & pullup_en_q[gi]
                                & direction_q[gi];
            // compare against the value latched at the last access
            assign mismatch[gi] = change_en_q[gi]
                                & (pins_digital[gi]
                                   ^ last_read_q[gi]);
        end
    endgenerate

    assign change_any  = |mismatch;
    assign port_access = (wr_en & (wr_sel == SEL_PIN))
                       | (rd_en & (rd_sel == SEL_PIN));
    assign wr_intctl   = wr_lane0 & (wr_sel == SEL_INTCTL);

    // ------------------------------------------------------------------
    // output latch: a lane-0 write stores new data, a write without lane 0 stores pins
    // ------------------------------------------------------------------
    // no lane 0: pins are sampled back,
    // as a bit update does; an analog
    // output pin then latches zero
    always @* begin
        latch_d = latch_q;
        if (wr_en && (wr_sel == SEL_PIN)) begin
            if (wr_strb[0]) begin
                latch_d = wr_data[7:0];
            end else begin
                latch_d = pins_digital;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_any_n) begin
            latch_q     <= `PBG_RST_LATCH;
            direction_q <= `PBG_RST_DIRECTION;
            analog_q    <= `PBG_RST_ANALOG_SEL;
            pullup_en_q <= `PBG_RST_PULLUP_EN;
            change_en_q <= `PBG_RST_CHANGE_EN;
            gpu_dis_q   <= `PBG_RST_GPU_DIS;
            change_ie_q <= 1'h0;
        end else begin
            latch_q <= latch_d;
            if (wr_lane0) begin
                case (wr_sel)
                    SEL_DIR: begin
                        direction_q <= wr_data[7:0];
                    end
                    SEL_ANALOG: begin
                        analog_q <= wr_data[7:0] & `PBG_ANALOG_MASK;
                    end
                    SEL_PULLUP: begin
                        pullup_en_q <= wr_data[7:0];
                    end
                    SEL_CHANGE: begin
                        change_en_q <= wr_data[7:0];
                    end
                    SEL_OPTION: begin
                        gpu_dis_q <= wr_data[`PBG_BIT_GPU_DIS];
                    end
                    SEL_INTCTL: begin
                        change_ie_q <= wr_data[`PBG_BIT_CHG_IE];
                    end
                    default: begin
                        change_ie_q <= change_ie_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // last-access latch
    // ------------------------------------------------------------------
    // only power-on clears it, so a
    // mismatch survives other resets
    always @(posedge clk) begin
        if (!por_n) begin
            last_read_q <= `PBG_RST_LAST_READ;
        end else if (port_access) begin
            last_read_q <= pins_digital;
        end
    end

    // ------------------------------------------------------------------
    // change flag
    // ------------------------------------------------------------------
    // set beats a software clear; a read
    // compares with the old latch
    always @* begin
        flag_d = flag_q;
        if (wr_intctl) begin
            flag_d = wr_data[`PBG_BIT_CHG_FLAG];
        end
        if (change_any) begin
            flag_d = 1'h1;
        end
    end

    always @(posedge clk) begin
        if (!rst_any_n) begin
            flag_q <= 1'h0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------------
    // pad drive and status outputs
    // ------------------------------------------------------------------
    // registered so that pads never see decode glitches
    always @(posedge clk) begin
        if (!rst_any_n) begin
            pullup_q <= 8'h00;
            wake_q   <= 1'h0;
        end else begin
            pullup_q <= pullup_d;
            wake_q   <= flag_q & change_ie_q;
        end
    end

    // the driver follows the direction bit alone, analog or not
    assign port_b_pins_oe_n   = direction_q;
    assign port_b_pins_o      = latch_q;
    // masked by the live direction so an output never sees a pull-up
    assign port_b_pullup_on   = pullup_q & direction_q;
    assign port_b_analog_on   = analog_q;
    assign port_b_change_flag = flag_q;
    assign port_b_wake        = wake_q;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always @* begin
        rd_data = 32'h00000000;
        case (rd_sel)
            SEL_PIN: begin
                rd_data[7:0] = pins_digital;
            end
            SEL_DIR: begin
                rd_data[7:0] = direction_q;
            end
            SEL_ANALOG: begin
                rd_data[7:0] = analog_q;
            end
            SEL_PULLUP: begin
                rd_data[7:0] = pullup_en_q;
            end
            SEL_CHANGE: begin
                rd_data[7:0] = change_en_q;
            end
            SEL_OPTION: begin
                rd_data[`PBG_BIT_GPU_DIS] = gpu_dis_q;
            end
            SEL_INTCTL: begin
                rd_data[`PBG_BIT_CHG_FLAG] = flag_q;
                rd_data[`PBG_BIT_CHG_IE]   = change_ie_q;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

endmodule // pbg_port_b_top

// File: dv/pbg_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port b checker
// ----------------------------------------
module pbg_props (
    input wire        clk,
    input wire        rst_n,
    input wire        por_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire [7:0]  port_b_pins_o,
    input wire [7:0]  port_b_pins_oe_n,
    input wire [7:0]  port_b_pullup_on,
    input wire        port_b_change_flag,
    input wire        port_b_wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !por_n);

    a_pullup_out: assert property (
        (port_b_pullup_on & ~port_b_pins_oe_n) == 8'h00)
        else $error("pull-up on output");
    a_wake_after: assert property (
        port_b_wake |-> $past(port_b_change_flag))
        else $error("wake without flag");
    a_flag_hold: assert property (
        $fell(port_b_change_flag) |-> $rose(s_axi_bvalid))
        else $error("flag fell without write");
    a_latch_by_wr: assert property (
        !$stable(port_b_pins_o) |-> $rose(s_axi_bvalid))
        else $error("latch moved without write");
    a_dir_by_wr: assert property (
        !$stable(port_b_pins_oe_n) |-> $rose(s_axi_bvalid))
        else $error("drive moved without write");
    a_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_por_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(por_n) |-> port_b_pullup_on == 8'h00 && !port_b_change_flag)
        else $error("por left pull-up or flag");

    c_flag: cover property (port_b_change_flag);
    c_wake: cover property (port_b_wake);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // pbg_props

bind pbg_port_b_top pbg_props u_props (
    .clk, .rst_n, .por_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
    .port_b_pins_o, .port_b_pins_oe_n, .port_b_pullup_on,
    .port_b_change_flag, .port_b_wake
);

// File: dv/pbg_pins_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// board side of the port b pads
// ----------------------------------------
module pbg_pins_model (
    input  wire       clk,
    input  wire [7:0] drv_o,
    input  wire [7:0] drv_oe_n,
    input  wire [7:0] pull_on,
    input  wire [7:0] ext_val,
    input  wire [7:0] ext_en,
    output wire [7:0] pad
);
    reg [7:0] flt_q = 8'h55;
    // floating pad toggles so stale data shows
    always @(posedge clk) begin
        flt_q <= ~flt_q;
    end
    // device, then board, then pull-up, else float
    assign pad = (~drv_oe_n & drv_o) | (drv_oe_n & ext_en & ext_val)
               | (drv_oe_n & ~ext_en & (pull_on | flt_q));
endmodule // pbg_pins_model

// File: dv/port_b_gpio_with_change_irq_bench.sv
`timescale 1ns/1ps
`include "pbg_consts.vh"
module port_b_gpio_with_change_irq_bench;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         por_n = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    reg  [7:0]  ext_val = 8'h00, ext_en = 8'h00;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, port_b_change_flag, port_b_wake;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  port_b_pins_i, port_b_pins_o, port_b_pins_oe_n;
    wire [7:0]  port_b_pullup_on, port_b_analog_on;
    int         num_errors = 0, n_tests = 0;
    reg  [31:0] d;
    reg  [1:0]  r;

    pbg_port_b_top DUT (.clk, .rst_n, .por_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_b_pins_i,
        .port_b_pins_o, .port_b_pins_oe_n, .port_b_pullup_on,
        .port_b_analog_on, .port_b_change_flag, .port_b_wake);
    pbg_pins_model u_pins (.clk, .drv_o(port_b_pins_o),
        .drv_oe_n(port_b_pins_oe_n), .pull_on(port_b_pullup_on),
        .ext_val, .ext_en, .pad(port_b_pins_i));

    // 10 MHz clock
    always #50 clk = ~clk;

    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // each channel holds until its own ready is seen at an edge
    task wr(input [7:0] a, input [31:0] v, input [3:0] s);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) ||
                   (s_axi_wvalid && !s_axi_wready));
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        #1; // pad outputs register one edge after the write
    endtask

    task rd(input [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input [7:0] a, input [31:0] e, input string nm);
        rd(a);
        chk(nm, d, e);
    endtask

    // reset held four cycles; p also pulls power-on
    task rst_pulse(input p);
        @(posedge clk);
        rst_n <= 1'b0;
        if (p) por_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task finish_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog: tests need under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test;
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge clk);
        rchk(`PBG_OFS_DIRECTION, `PBG_RST_DIRECTION, "dir");
        rchk(`PBG_OFS_ANALOG_SEL, `PBG_RST_ANALOG_SEL, "ansel");
        rchk(`PBG_OFS_PULLUP_EN, `PBG_RST_PULLUP_EN, "puen");
        rchk(`PBG_OFS_CHANGE_EN, 32'h00, "chen");
        rchk(`PBG_OFS_OPTION, 32'h01, "opt");
        chk("pu", port_b_pullup_on, 8'h00);
        // pull-ups need the global disable clear and an input pin
        wr(`PBG_OFS_OPTION, 32'h0, 4'hF);
        chk("pu", port_b_pullup_on, 8'hFF);
        wr(`PBG_OFS_DIRECTION, 32'hF0, 4'hF);
        chk("pu", port_b_pullup_on, 8'hF0);
        wr(`PBG_OFS_PULLUP_EN, 32'hA5, 4'hF);
        chk("pu", port_b_pullup_on, 8'hA0);
        // low nibble driven by the latch, high nibble by the board
        wr(`PBG_OFS_ANALOG_SEL, 32'h0, 4'hF);
        ext_en <= 8'hF0;
        ext_val <= 8'h90;
        wr(`PBG_OFS_PIN_STATE, 32'h3C, 4'hF);
        chk("out", port_b_pins_o, 8'h3C);
        chk("oe_n", port_b_pins_oe_n, 8'hF0);
        rchk(`PBG_OFS_PIN_STATE, 32'h9C, "pins");
        wr(`PBG_OFS_PIN_STATE, 32'h0, 4'h0);
        chk("out", port_b_pins_o, 8'h9C);
        // analog pins read zero but keep driving
        wr(`PBG_OFS_ANALOG_SEL, 32'h0C, 4'hF);
        rchk(`PBG_OFS_PIN_STATE, 32'h90, "ana");
        chk("out", port_b_pins_o, 8'h9C);
        chk("oe_n", port_b_pins_oe_n, 8'hF0);
        wr(`PBG_OFS_ANALOG_SEL, 32'hFF, 4'hF);
        rchk(`PBG_OFS_ANALOG_SEL, 32'h3F, "ansel");
        wr(`PBG_OFS_ANALOG_SEL, 32'h0, 4'hF);
        // pin 7 changes while the port read is under way
        wr(`PBG_OFS_CHANGE_EN, 32'h80, 4'hF);
        wr(`PBG_OFS_INT_CTRL, 32'h02, 4'hF);
        ext_val <= 8'h10;
        rd(`PBG_OFS_PIN_STATE);
        repeat (4) @(posedge clk);
        chk("flag", port_b_change_flag, 1'b1);
        chk("wake", port_b_wake, 1'b1);
        wr(`PBG_OFS_INT_CTRL, 32'h02, 4'hF);
        chk("flag", port_b_change_flag, 1'b1);
        rd(`PBG_OFS_PIN_STATE);
        wr(`PBG_OFS_INT_CTRL, 32'h02, 4'hF);
        chk("flag", port_b_change_flag, 1'b0);
        rchk(`PBG_OFS_INT_CTRL, 32'h02, "ictl");
        ext_val <= 8'h50;
        repeat (4) @(posedge clk);
        chk("flag", port_b_change_flag, 1'b0);
        // master clear keeps the last-access latch
        rd(`PBG_OFS_PIN_STATE);
        ext_val <= 8'hD0;
        rst_pulse(1'b0);
        wr(`PBG_OFS_CHANGE_EN, 32'h80, 4'hF);
        repeat (4) @(posedge clk);
        chk("flag", port_b_change_flag, 1'b1);
        wr(`PBG_OFS_OPTION, 32'h0, 4'hF);
        rst_pulse(1'b1);
        rchk(`PBG_OFS_OPTION, 32'h01, "opt");
        rchk(`PBG_OFS_CHANGE_EN, 32'h00, "chen");
        // unmapped place answers with an error and no data
        rd(8'h40);
        chk("rresp", r, `PBG_RESP_SLVERR);
        chk("rdata", d, 32'h0);
        wr(8'h40, 32'hFF, 4'hF);
        chk("bresp", r, `PBG_RESP_SLVERR);
        finish_test;
    end
endmodule // port_b_gpio_with_change_irq_bench
